// File: common/radio_mode_regs.svh
// constants for the radio operating-mode controller
// assumes a 10 MHz core clock; included by bare name
`ifndef RADIO_MODE_REGS_SVH
`define RADIO_MODE_REGS_SVH
`define CLK_PERIOD_NS 100
`define CE_PULSE_MIN_NS 10000
`define CE_PULSE_CYC (((`CE_PULSE_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define CD_HOLD_MIN_NS 128000
`define CD_HOLD_CYC (((`CD_HOLD_MIN_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define BASE_FREQ_MHZ 12'h960
`define RETRY_DELAY_STEP_NS 250000
`define RETRY_DELAY_STEP_CYC ((`RETRY_DELAY_STEP_NS) / (`CLK_PERIOD_NS))
`define RATE_1M 2'h0
`define RATE_2M 2'h1
`define RATE_250K 2'h2
`define CNT_W 12
`define SYNC_W 2
`endif

// File: common/radio_mode_pkg.sv
// types shared by the radio operating-mode controller
// no dependencies
`default_nettype none
package radio_mode_pkg;
   // operating modes, gray coded along the usual path
   typedef enum logic [2:0] {
      MODE_POWER_DOWN = 3'h0,
      MODE_STANDBY1 = 3'h1,
      MODE_STANDBY2 = 3'h3,
      MODE_TX = 3'h2,
      MODE_RX = 3'h6
   } mode_t;
   // configuration bits written by the controller
   typedef struct packed {
      logic power_enable_bit;
      logic receive_role_bit;
      logic auto_ack_enable;
      logic [3:0] retry_limit;
      logic [3:0] retry_delay;
      logic [6:0] channel_value;
      logic rate_select_hi;
      logic rate_select_lo;
   } config_t;
   // radio events and fifo status
   typedef struct packed {
      logic tx_fifo_empty;
      logic rx_fifo_full;
      logic tx_done;
      logic tx_no_ack;
      logic ack_received;
      logic ack_timeout;
      logic rx_valid;
      logic rx_no_ack;
      logic ack_sent;
      logic signal_detect;
   } events_t;
endpackage : radio_mode_pkg
`default_nettype wire

// File: hdl/sync_stage.sv
// two-flop synchroniser for one asynchronous level
// assumes clk is the block clock and ce gates all state
`timescale 1ns/10ps
`default_nettype none
module sync_stage (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic async_in,
   output logic sync_out
);
   logic meta_q;
   // first flop feeds only the second one
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_out <= 1'b0;
      end else if (ce) begin
         meta_q <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule : sync_stage
`default_nettype wire

// File: hdl/radio_mode_ctrl.sv
// operating-mode controller of a packet radio transceiver
// assumes config and events come from same-clock logic; chip enable,
// serial select and signal detect arrive asynchronously from outside
//
// Function
// - carrier frequency in MHz is 2400 plus channel value, 1 MHz steps
// - two rate bits choose 250 kbps, 1 Mbps or 2 Mbps
// - both link ends need equal channel and rate settings
// - power enable low gives power down; serial port stays usable
// - power enable high and chip enable low gives standby-I
// - chip enable low drops transmit or receive to standby-I
// - transmitter with chip enable high and empty fifo sits in standby-II
// - payload loaded in standby-II starts transmit at once
// - transmit starts after chip enable pulse over 10 us with payload
// - packet finishes first; then standby-I, next packet or standby-II
// - with auto-ack, retransmit after retry delay while count below limit
// - transmitter goes to receive for ack only if auto-ack and ack wanted
// - receiver sends ack only if auto-ack and packet wants one
// - receive entered from standby-I with power, receive role, chip enable
// - after sending ack, receiver returns to receive
// - receive accepts packets with matching address and good crc
// - valid packet dropped when receive fifo full
// - receiver stays in receive until standby-I or power down
// - carrier detect rises only after signal held 128 us
// - without auto-ack no autonomous transitions
// - interrupt active low and maskable; serial select low; data out tristate
// - no-ack packet sends transmitter straight to standby-I
`timescale 1ns/10ps
`default_nettype none
`include "radio_mode_regs.svh"
module radio_mode_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic chip_enable,
   input wire logic serial_select_n,
   input wire logic serial_data_out,
   input wire logic irq_request,
   input wire logic irq_mask,
   input wire radio_mode_pkg::config_t cfg,
   input wire radio_mode_pkg::events_t evt,
   output var radio_mode_pkg::mode_t mode,
   output logic [11:0] carrier_freq_mhz,
   output logic [1:0] air_rate,
   output logic start_packet,
   output logic rx_accept,
   output logic rx_drop,
   output logic carrier_detect,
   output logic [3:0] retry_count,
   output logic retry_exhausted_flag,
   output logic irq_n,
   output logic miso_out,
   output logic miso_oe
);
   radio_mode_pkg::mode_t mode_d;
   logic chip_en_s;
   logic sel_n_s;
   logic sig_s;
   logic ce_armed_q;
   logic [`CNT_W-1:0] ce_cnt_q;
   logic [`CNT_W-1:0] cd_cnt_q;
   logic [15:0] delay_cnt_q;
   logic waiting_retry_q;
   logic delay_done;
   logic retry_ok;

   // pins from outside pass two flops before any use
   sync_stage u_sync_ce (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(chip_enable), .sync_out(chip_en_s));
   sync_stage u_sync_sel (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(serial_select_n), .sync_out(sel_n_s));
   sync_stage u_sync_sig (.clk(clk), .rst_n(rst_n), .ce(ce), .async_in(evt.signal_detect), .sync_out(sig_s));

   // chip enable width qualifier: the pulse must outlast the minimum
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ce_cnt_q <= '0;
         ce_armed_q <= 1'b0;
      end else if (ce) begin
         if (!chip_en_s) begin
            ce_cnt_q <= '0;
         end else if (ce_cnt_q != `CNT_W'(`CE_PULSE_CYC)) begin
            ce_cnt_q <= ce_cnt_q + `CNT_W'(1);
         end
         // armed once the pulse is long enough, held until transmit starts or power enable goes low
         if (chip_en_s && ce_cnt_q == `CNT_W'(`CE_PULSE_CYC - 1)) begin
            ce_armed_q <= 1'b1;
         end else if (mode == radio_mode_pkg::MODE_TX || !cfg.power_enable_bit) begin
            ce_armed_q <= 1'b0;
         end
      end
   end

   // retry delay wait; the programmed field plus one sets the number of fixed delay steps
   assign delay_done = waiting_retry_q &&
      delay_cnt_q == 16'(({12'h0, cfg.retry_delay} + 16'h1) * 16'(`RETRY_DELAY_STEP_CYC) - 16'h1);
   assign retry_ok = retry_count < cfg.retry_limit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         delay_cnt_q <= '0;
         waiting_retry_q <= 1'b0;
         retry_count <= '0;
         retry_exhausted_flag <= 1'b0;
      end else if (ce) begin
         if (mode == radio_mode_pkg::MODE_RX && !cfg.receive_role_bit && evt.ack_timeout) begin
            // lost ack: either wait and retry or give up
            if (retry_ok) begin
               waiting_retry_q <= 1'b1;
               retry_count <= retry_count + 4'h1;
            end else begin
               retry_exhausted_flag <= 1'b1;
            end
            delay_cnt_q <= '0;
         end else if (delay_done || mode != radio_mode_pkg::MODE_STANDBY1) begin
            waiting_retry_q <= 1'b0;
            delay_cnt_q <= '0;
         end else if (waiting_retry_q) begin
            delay_cnt_q <= delay_cnt_q + 16'h1;
         end
         // a new transaction clears the count and the flag
         if (mode == radio_mode_pkg::MODE_STANDBY2 && !evt.tx_fifo_empty) begin
            retry_count <= '0;
            retry_exhausted_flag <= 1'b0;
         end else if (ce_armed_q && mode == radio_mode_pkg::MODE_STANDBY1 && !waiting_retry_q) begin
            retry_count <= '0;
            retry_exhausted_flag <= 1'b0;
         end
      end
   end

   // next-mode logic
   always_comb begin
      mode_d = mode;
      unique case (mode)
         radio_mode_pkg::MODE_POWER_DOWN: begin
            if (cfg.power_enable_bit) begin
               mode_d = radio_mode_pkg::MODE_STANDBY1;
            end
         end
         radio_mode_pkg::MODE_STANDBY1: begin
            if (cfg.receive_role_bit && chip_en_s) begin
               mode_d = radio_mode_pkg::MODE_RX;
            end else if (!cfg.receive_role_bit && cfg.auto_ack_enable && delay_done) begin
               // the limit was already checked when the wait began; the count is one higher now
               mode_d = radio_mode_pkg::MODE_TX;
            end else if (!cfg.receive_role_bit && ce_armed_q && !evt.tx_fifo_empty) begin
               mode_d = radio_mode_pkg::MODE_TX;
            end else if (!cfg.receive_role_bit && chip_en_s && evt.tx_fifo_empty) begin
               mode_d = radio_mode_pkg::MODE_STANDBY2;
            end
         end
         radio_mode_pkg::MODE_STANDBY2: begin
            if (!chip_en_s) begin
               mode_d = radio_mode_pkg::MODE_STANDBY1;
            end else if (!evt.tx_fifo_empty) begin
               mode_d = radio_mode_pkg::MODE_TX;
            end
         end
         radio_mode_pkg::MODE_TX: begin
            // only power-down leaves transmit before the packet ends
            if (evt.tx_done) begin
               if (cfg.receive_role_bit) begin
                  mode_d = radio_mode_pkg::MODE_RX;
               end else if (cfg.auto_ack_enable && !evt.tx_no_ack) begin
                  mode_d = radio_mode_pkg::MODE_RX;
               end else if (!chip_en_s || evt.tx_no_ack) begin
                  mode_d = radio_mode_pkg::MODE_STANDBY1;
               end else if (evt.tx_fifo_empty) begin
                  mode_d = radio_mode_pkg::MODE_STANDBY2;
               end
            end
         end
         radio_mode_pkg::MODE_RX: begin
            if (!chip_en_s) begin
               mode_d = radio_mode_pkg::MODE_STANDBY1;
            end else if (cfg.receive_role_bit && cfg.auto_ack_enable && evt.rx_valid
                         && !evt.rx_no_ack && !evt.rx_fifo_full) begin
               mode_d = radio_mode_pkg::MODE_TX;
            end else if (!cfg.receive_role_bit && evt.ack_timeout) begin
               mode_d = radio_mode_pkg::MODE_STANDBY1;
            end else if (!cfg.receive_role_bit && evt.ack_received) begin
               mode_d = evt.tx_fifo_empty ? radio_mode_pkg::MODE_STANDBY2 : radio_mode_pkg::MODE_TX;
            end
         end
         default: mode_d = radio_mode_pkg::MODE_POWER_DOWN;
      endcase
      // power-down overrides all else at once; chip enable low also forces standby-I from standby-II
      if (!cfg.power_enable_bit) begin
         mode_d = radio_mode_pkg::MODE_POWER_DOWN;
      end else if (!chip_en_s && mode == radio_mode_pkg::MODE_STANDBY2) begin
         mode_d = radio_mode_pkg::MODE_STANDBY1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode <= radio_mode_pkg::MODE_POWER_DOWN;
         start_packet <= 1'b0;
      end else if (ce) begin
         mode <= mode_d;
         start_packet <= (mode_d == radio_mode_pkg::MODE_TX) && (mode != radio_mode_pkg::MODE_TX
                         || evt.tx_done);
      end
   end

   // frequency and rate follow the config of this end only; nothing here keeps both ends equal
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         carrier_freq_mhz <= `BASE_FREQ_MHZ;
         air_rate <= `RATE_1M;
      end else if (ce) begin
         carrier_freq_mhz <= `BASE_FREQ_MHZ + {5'h0, cfg.channel_value};
         if (cfg.rate_select_lo) begin
            air_rate <= `RATE_250K;
         end else if (cfg.rate_select_hi) begin
            air_rate <= `RATE_2M;
         end else begin
            air_rate <= `RATE_1M;
         end
      end
   end

   // packet acceptance in receive mode
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_accept <= 1'b0;
         rx_drop <= 1'b0;
      end else if (ce) begin
         rx_accept <= mode == radio_mode_pkg::MODE_RX && evt.rx_valid && !evt.rx_fifo_full;
         rx_drop <= mode == radio_mode_pkg::MODE_RX && evt.rx_valid && evt.rx_fifo_full;
      end
   end

   // carrier detect filter; short bursts of signal never reach the flag
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cd_cnt_q <= '0;
         carrier_detect <= 1'b0;
      end else if (ce) begin
         if (mode != radio_mode_pkg::MODE_RX || !sig_s) begin
            cd_cnt_q <= '0;
            carrier_detect <= 1'b0;
         end else if (cd_cnt_q != `CNT_W'(`CD_HOLD_CYC)) begin
            cd_cnt_q <= cd_cnt_q + `CNT_W'(1);
         end else begin
            carrier_detect <= 1'b1;
         end
      end
   end

   // interrupt and serial data pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_n <= 1'b1;
         miso_out <= 1'b0;
         miso_oe <= 1'b0;
      end else if (ce) begin
         irq_n <= !(irq_request && !irq_mask);
         miso_out <= serial_data_out;
         miso_oe <= !sel_n_s;
      end
   end

   a_cd_filter: assert property (@(posedge clk) disable iff (!rst_n)
      $rose(carrier_detect) |-> $past(sig_s, 8) && $past(mode) == radio_mode_pkg::MODE_RX
      && $past(cd_cnt_q) == `CNT_W'(`CD_HOLD_CYC))
      else $error("carrier detect rose without held signal");
   a_ce_low_exit: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.power_enable_bit && !chip_en_s && mode == radio_mode_pkg::MODE_RX
      |=> mode == radio_mode_pkg::MODE_STANDBY1)
      else $error("receive did not fall back on chip enable low");
   a_pd_enter: assert property (@(posedge clk) disable iff (!rst_n)
      ce && !cfg.power_enable_bit |=> mode == radio_mode_pkg::MODE_POWER_DOWN)
      else $error("power down not entered");
   a_tx_finish: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.power_enable_bit && mode == radio_mode_pkg::MODE_TX && !evt.tx_done
      |=> mode == radio_mode_pkg::MODE_TX)
      else $error("transmit left before packet end");
   a_sb2_load: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.power_enable_bit && chip_en_s && mode == radio_mode_pkg::MODE_STANDBY2 && !evt.tx_fifo_empty
      |=> mode == radio_mode_pkg::MODE_TX && start_packet)
      else $error("standby-II did not start transmit");
   a_rx_drop: assert property (@(posedge clk) disable iff (!rst_n)
      ce && mode == radio_mode_pkg::MODE_RX && evt.rx_valid && evt.rx_fifo_full |=> rx_drop && !rx_accept)
      else $error("full fifo packet not dropped");
   a_ack_gate: assert property (@(posedge clk) disable iff (!rst_n)
      ce && cfg.receive_role_bit && mode == radio_mode_pkg::MODE_RX && mode_d == radio_mode_pkg::MODE_TX
      |-> cfg.auto_ack_enable && !evt.rx_no_ack)
      else $error("ack sent without auto-ack");
   a_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
      ce && irq_mask |=> irq_n)
      else $error("masked interrupt asserted");
   a_freq_calc: assert property (@(posedge clk) disable iff (!rst_n)
      ce ##1 $stable(cfg.channel_value) |-> carrier_freq_mhz == `BASE_FREQ_MHZ + {5'h0, cfg.channel_value})
      else $error("carrier frequency wrong");
endmodule : radio_mode_ctrl
`default_nettype wire

// File: sim/mcu_link_model.sv
// controller side of the mode block: chip enable and serial select pins
// assumes its own free-running 800 ns clock, unrelated in phase to clk
`timescale 1ns/10ps
`default_nettype none
module mcu_link_model (
   input wire logic ce_req,
   input wire logic sel_req,
   output logic chip_enable,
   output logic serial_select_n
);
   logic link_clk = 1'b0;
   // offset start so pin moves never line up with block clock edges
   initial begin
      #37;
      forever #400 link_clk = ~link_clk;
   end
   // pins follow bench requests; starts are held far past 10 us, tx runs kept far below 4 ms
   always @(posedge link_clk) begin
      chip_enable <= ce_req;
      serial_select_n <= ~sel_req;
   end
endmodule : mcu_link_model
`default_nettype wire

// File: sim/testbench.sv
// self-checking bench for the radio operating-mode controller
// assumes the controller model drives the async pins; mode changes checked in order
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce_req = 1'b0;
   logic sel_req = 1'b0;
   logic chip_enable, serial_select_n, sdo, irq_request, irq_mask;
   radio_mode_pkg::config_t cfg;
   radio_mode_pkg::events_t evt;
   radio_mode_pkg::mode_t mode, prev_mode, want_mode;
   logic [11:0] freq;
   logic [1:0] air_rate;
   logic rx_accept, rx_drop, carrier_detect, irq_n, miso_out, miso_oe;
   logic start_packet, retry_exhausted_flag;
   logic [3:0] retry_count;
   logic clk_en = 1'b1;
   radio_mode_pkg::mode_t exp_q[$];
   int err_total = 0;
   int n_compared = 0;
   always #50 clk = ~clk;
   mcu_link_model mcu_link_model_inst (.ce_req(ce_req), .sel_req(sel_req), .chip_enable(chip_enable),
      .serial_select_n(serial_select_n));
   radio_mode_ctrl radio_mode_ctrl_inst (.clk(clk), .rst_n(rst_n), .ce(clk_en), .chip_enable(chip_enable),
      .serial_select_n(serial_select_n), .serial_data_out(sdo), .irq_request(irq_request),
      .irq_mask(irq_mask), .cfg(cfg), .evt(evt), .mode(mode), .carrier_freq_mhz(freq), .air_rate(air_rate),
      .start_packet(start_packet), .rx_accept(rx_accept), .rx_drop(rx_drop), .carrier_detect(carrier_detect),
      .retry_count(retry_count), .retry_exhausted_flag(retry_exhausted_flag), .irq_n(irq_n),
      .miso_out(miso_out), .miso_oe(miso_oe));
   task automatic results();
      if (err_total == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   task automatic check(input logic [11:0] got, input logic [11:0] want);
      n_compared++;
      if (got !== want) begin
         err_total++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : check
   // bounded wait for a mode; running out ends the run
   task automatic wait_mode(input radio_mode_pkg::mode_t m, input int bound);
      int i;
      i = 0;
      while (mode !== m && i < bound) begin
         @(negedge clk);
         i++;
      end
      if (mode !== m) begin
         check({9'h000, mode}, {9'h000, m});
         results();
      end
   endtask : wait_mode
   // each mode change takes the oldest noted expectation
   always @(negedge clk) begin
      if (rst_n && mode !== prev_mode) begin
         if (exp_q.size() == 0) begin
            exp_q.push_back(radio_mode_pkg::mode_t'(3'h7));
         end
         want_mode = exp_q.pop_front();
         check({9'h000, mode}, {9'h000, want_mode});
      end
      prev_mode = mode;
   end
   // main sequence, inputs move on the falling edge
   initial begin
      int i;
      logic [6:0] ch;
      logic [1:0] r;
      void'($urandom(32'hdc64));
      sdo = 1'b0;
      irq_request = 1'b0;
      irq_mask = 1'b0;
      cfg = '0;
      evt = '0;
      evt.tx_fifo_empty = 1'b1;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      check({9'h000, mode}, 12'h000);
      check(freq, 12'h960);
      // channel and rate settings, top channel first
      for (i = 0; i < 6; i++) begin
         ch = (i == 0) ? 7'h7F : 7'($urandom());
         r = 2'(i);
         cfg.channel_value = ch;
         {cfg.rate_select_hi, cfg.rate_select_lo} = r;
         repeat (2) @(negedge clk);
         check(freq, 12'h960 + {5'h00, ch});
         check({10'h000, air_rate}, r[0] ? 12'h002 : (r[1] ? 12'h001 : 12'h000));
      end
      exp_q.push_back(radio_mode_pkg::MODE_STANDBY1);
      cfg.power_enable_bit = 1'b1;
      wait_mode(radio_mode_pkg::MODE_STANDBY1, 4);
      // transmitter: a start needs chip enable held 10 us
      cfg.auto_ack_enable = 1'b1;
      evt.tx_fifo_empty = 1'b0;
      exp_q.push_back(radio_mode_pkg::MODE_TX);
      ce_req = 1'b1;
      repeat (60) @(negedge clk);
      check({9'h000, mode}, 12'h001);
      wait_mode(radio_mode_pkg::MODE_TX, 200);
      check({11'h000, start_packet}, 12'h001);
      exp_q.push_back(radio_mode_pkg::MODE_RX);
      evt.tx_done = 1'b1;
      @(negedge clk);
      evt.tx_done = 1'b0;
      wait_mode(radio_mode_pkg::MODE_RX, 4);
      exp_q.push_back(radio_mode_pkg::MODE_STANDBY2);
      evt.tx_fifo_empty = 1'b1;
      evt.ack_received = 1'b1;
      @(negedge clk);
      evt.ack_received = 1'b0;
      wait_mode(radio_mode_pkg::MODE_STANDBY2, 4);
      exp_q.push_back(radio_mode_pkg::MODE_TX);
      evt.tx_fifo_empty = 1'b0;
      wait_mode(radio_mode_pkg::MODE_TX, 4);
      check({11'h000, start_packet}, 12'h001);
      // chip enable low mid-packet: the packet still finishes first
      exp_q.push_back(radio_mode_pkg::MODE_STANDBY1);
      ce_req = 1'b0;
      repeat (30) @(negedge clk);
      check({9'h000, mode}, 12'h002);
      evt.tx_done = 1'b1;
      evt.tx_no_ack = 1'b1;
      @(negedge clk);
      evt.tx_done = 1'b0;
      evt.tx_no_ack = 1'b0;
      wait_mode(radio_mode_pkg::MODE_STANDBY1, 4);
      // lost acks: one retry after the delay, then the give-up flag
      cfg.retry_limit = 4'h1;
      cfg.retry_delay = 4'h0;
      exp_q.push_back(radio_mode_pkg::MODE_TX);
      ce_req = 1'b1;
      wait_mode(radio_mode_pkg::MODE_TX, 200);
      for (i = 0; i < 2; i++) begin
         exp_q.push_back(radio_mode_pkg::MODE_RX);
         exp_q.push_back(radio_mode_pkg::MODE_STANDBY1);
         evt.tx_done = 1'b1;
         @(negedge clk);
         evt.tx_done = 1'b0;
         wait_mode(radio_mode_pkg::MODE_RX, 4);
         evt.ack_timeout = 1'b1;
         @(negedge clk);
         evt.ack_timeout = 1'b0;
         wait_mode(radio_mode_pkg::MODE_STANDBY1, 4);
         check({7'h00, retry_exhausted_flag, retry_count}, i[0] ? 12'h011 : 12'h001);
         if (i == 0) begin
            // retry delay of one step is 2500 cycles
            exp_q.push_back(radio_mode_pkg::MODE_TX);
            repeat (2490) @(negedge clk);
            check({9'h000, mode}, 12'h001);
            wait_mode(radio_mode_pkg::MODE_TX, 20);
            check({11'h000, start_packet}, 12'h001);
         end
      end
      // receiver
      cfg.receive_role_bit = 1'b1;
      evt.tx_fifo_empty = 1'b1;
      exp_q.push_back(radio_mode_pkg::MODE_RX);
      ce_req = 1'b1;
      wait_mode(radio_mode_pkg::MODE_RX, 40);
      for (i = 0; i < 4; i++) begin
         cfg.auto_ack_enable = i[1];
         evt.rx_no_ack = i[1];
         evt.rx_fifo_full = i[0];
         evt.rx_valid = 1'b1;
         @(negedge clk);
         evt.rx_valid = 1'b0;
         check({10'h000, rx_accept, rx_drop}, i[0] ? 12'h001 : 12'h002);
      end
      evt.rx_fifo_full = 1'b0;
      evt.rx_no_ack = 1'b0;
      exp_q.push_back(radio_mode_pkg::MODE_TX);
      exp_q.push_back(radio_mode_pkg::MODE_RX);
      evt.rx_valid = 1'b1;
      @(negedge clk);
      evt.rx_valid = 1'b0;
      wait_mode(radio_mode_pkg::MODE_TX, 4);
      evt.tx_done = 1'b1;
      @(negedge clk);
      evt.tx_done = 1'b0;
      wait_mode(radio_mode_pkg::MODE_RX, 4);
      // carrier detect only after 1280 cycles of signal
      evt.signal_detect = 1'b1;
      repeat (1200) @(negedge clk);
      check({11'h000, carrier_detect}, 12'h000);
      repeat (100) @(negedge clk);
      check({11'h000, carrier_detect}, 12'h001);
      evt.signal_detect = 1'b0;
      // interrupt and serial data pin
      irq_request = 1'b1;
      repeat (2) @(negedge clk);
      check({11'h000, irq_n}, 12'h000);
      irq_mask = 1'b1;
      repeat (2) @(negedge clk);
      check({11'h000, irq_n}, 12'h001);
      sdo = 1'($urandom());
      sel_req = 1'b1;
      repeat (20) @(negedge clk);
      check({10'h000, miso_oe, miso_out}, {10'h000, 1'b1, sdo});
      sel_req = 1'b0;
      repeat (20) @(negedge clk);
      check({11'h000, miso_oe}, 12'h000);
      exp_q.push_back(radio_mode_pkg::MODE_STANDBY1);
      ce_req = 1'b0;
      wait_mode(radio_mode_pkg::MODE_STANDBY1, 40);
      // clock enable low freezes the mode even with power enable cleared
      clk_en = 1'b0;
      cfg.power_enable_bit = 1'b0;
      repeat (8) @(negedge clk);
      check({9'h000, mode}, 12'h001);
      exp_q.push_back(radio_mode_pkg::MODE_POWER_DOWN);
      clk_en = 1'b1;
      wait_mode(radio_mode_pkg::MODE_POWER_DOWN, 4);
      repeat (2) @(negedge clk);
      check(12'(exp_q.size()), 12'h000);
      results();
   end
endmodule : testbench
`default_nettype wire
